// [bench/temp_sensor_model.sv]
// Behavioural external temperature sensor on the open-drain auxiliary bus.
// Assumes pull-ups on both lines; the model never stretches the clock.
`timescale 1ns/1ps
module temp_sensor_model #(
  parameter logic [7:0] ADDR = 8'h90,
  parameter logic [15:0] TEMP = 16'h1980
) (
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe
);
  logic [7:0] sh;
  logic [15:0] tx;
  logic sel;
  logic rd;
  logic adr;
  int n;
  initial begin
    sda_oe = 1'b0;
    sel = 1'b0;
    rd = 1'b0;
    adr = 1'b0;
    n = 0;
  end
  // Start or repeated start restarts the address phase
  always @(negedge sda) if (scl === 1'b1) begin
    n = 0;
    adr = 1'b1;
  end
  // Stop deselects and frees the data line so the pull-up shows
  always @(posedge sda) if (scl === 1'b1) begin
    sel = 1'b0;
    sda_oe <= 1'b0;
  end
  always @(posedge scl) begin
    n = n + 1;
    if (n <= 8) sh = {sh[6:0], sda};
    if (n == 8 && adr) begin
      sel = (sh[7:1] == ADDR[7:1]);
      rd = sh[0];
      tx = TEMP;
    end
    if (n == 9 && rd && !adr && sda) sel = 1'b0;
  end
  // Data changes only while the clock is low
  always @(negedge scl) begin
    if (n == 9) begin
      n = 0;
      adr = 1'b0;
    end
    if (n == 8 && (adr || !rd)) sda_oe <= sel;
    else if (sel && rd && !adr && n != 8) begin
      sda_oe <= !tx[15];
      tx = {tx[14:0], 1'b1};
    end
    else sda_oe <= 1'b0;
  end
endmodule

// [bench/temp_sensor_poller_test.sv]
// Self-checking bench for the temperature poller: host commands, internal samples, one bus sensor.
// Assumes the sensor model file is compiled first; channel 17 has no sensor so its init fails.
`timescale 1ns/1ps
module temp_sensor_poller_test;
  localparam logic [15:0] EXT_TEMP = 16'h1980;
  logic core_clk = 1'b0;
  logic link_clk;
  logic rstn = 1'b0;
  logic [4:0] cmd_page = 5'h00;
  logic [7:0] cmd_code = 8'h00;
  logic cmd_write = 1'b0;
  logic cmd_read = 1'b0;
  logic [15:0] cmd_wdata = 16'h0000;
  logic [15:0] cmd_rdata;
  logic cmd_rdata_valid;
  logic status_clear = 1'b0;
  logic mode_alert_enable = 1'b0;
  logic int_start;
  logic [15:0] int_sample = 16'h0000;
  logic int_sample_valid = 1'b0;
  logic temp_status_flag;
  logic temp_alert;
  logic clk_oe;
  logic clk_out;
  logic data_oe;
  logic data_out;
  logic model_oe;
  logic [15:0] samp [8] = '{16'h4100, 16'h4100, 16'h4100, 16'h4103, 16'h4104, 16'h4104, 16'h4104, 16'h4104};
  logic [15:0] val;
  int idx = 0;
  int err_count = 0;
  int comparisons = 0;
  int k;
  wire scl_line = ~clk_oe;
  wire sda_line = ~(data_oe | model_oe);

  always #5 core_clk = ~core_clk;
  initial begin
    link_clk = 1'b0;
    #1.7;
    forever #3 link_clk = ~link_clk;
  end

  // Shorter than a bus round on purpose: the tick after round one lands well after the test's host work
  temp_sensor_poller #(.POLL_CYCLES(12000)) i_temp_sensor_poller (
    .core_clk(core_clk), .rstn(rstn), .link_clk(link_clk), .cmd_page(cmd_page), .cmd_code(cmd_code),
    .cmd_write(cmd_write), .cmd_read(cmd_read), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
    .cmd_rdata_valid(cmd_rdata_valid), .status_clear(status_clear), .mode_alert_enable(mode_alert_enable),
    .int_start(int_start), .int_sample(int_sample), .int_sample_valid(int_sample_valid),
    .temp_status_flag(temp_status_flag), .temp_alert(temp_alert), .aux_bus_clock_in(scl_line),
    .aux_bus_clock_out(clk_out), .aux_bus_clock_oe(clk_oe), .aux_bus_data_in(sda_line),
    .aux_bus_data_out(data_out), .aux_bus_data_oe(data_oe));

  temp_sensor_model #(.ADDR(8'h90), .TEMP(EXT_TEMP)) i_temp_sensor_model (
    .scl(scl_line), .sda(sda_line), .sda_oe(model_oe));

  // Internal converter answers each start two cycles later; start is looked at mid-cycle, where it is settled,
  // and in the same step that drops valid, so a start right after a sample is not missed
  initial forever begin
    @(negedge core_clk);
    int_sample_valid = 1'b0;
    if (int_start === 1'b1) begin
      repeat (2) @(negedge core_clk);
      int_sample = samp[idx[2:0]];
      int_sample_valid = 1'b1;
      idx++;
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cmd_wr(input logic [4:0] pg, input logic [15:0] d);
    @(negedge core_clk);
    cmd_page = pg;
    cmd_code = temp_poll_pkg::CMD_CHANNEL_ENABLE;
    cmd_wdata = d;
    cmd_write = 1'b1;
    @(negedge core_clk);
    cmd_write = 1'b0;
  endtask

  task automatic cmd_rd(input logic [4:0] pg, input logic [7:0] code, output logic [15:0] v);
    int n;
    @(negedge core_clk);
    cmd_page = pg;
    cmd_code = code;
    cmd_read = 1'b1;
    @(negedge core_clk);
    cmd_read = 1'b0;
    for (n = 0; n < 3 && cmd_rdata_valid !== 1'b1; n++) @(negedge core_clk);
    v = (cmd_rdata_valid === 1'b1) ? cmd_rdata : 16'hxxxx;
  endtask

  task automatic rd_temp(input logic [4:0] pg, output logic [15:0] v);
    cmd_rd(pg, temp_poll_pkg::CMD_READ_TEMPERATURE, v);
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    // Two poll rounds with one slow sensor read take about 110k cycles
    repeat (150000) @(posedge core_clk);
    err_count++;
    report_and_stop;
  end

  initial begin
    repeat (16) @(negedge core_clk);
    rstn = 1'b1;
    cmd_rd(5'd13, temp_poll_pkg::CMD_CHANNEL_ENABLE, val);
    check("enable reset", val, 16'h8000);
    cmd_wr(5'd15, 16'h7fff);
    cmd_rd(5'd15, temp_poll_pkg::CMD_CHANNEL_ENABLE, val);
    check("enable low bits", val, 16'h0000);
    cmd_wr(5'd16, 16'h0000);
    rd_temp(5'd15, val);
    check("disabled reading", val, temp_poll_pkg::DISABLED_READING);
    cmd_rd(5'd3, temp_poll_pkg::CMD_READ_TEMPERATURE, val);
    check("bad page", val, 16'h0000);
    $display("test config done");
    // First round: internal at the hot limit, sensor 90h answers, 96h missing
    val = 16'h0000;
    for (k = 0; k < 200 && val !== EXT_TEMP; k++) begin
      repeat (1000) @(negedge core_clk);
      rd_temp(5'd14, val);
    end
    check("external reading", val, EXT_TEMP);
    rd_temp(5'd13, val);
    check("internal average", val, 16'h4100);
    // Page 17 is polled after page 14, so its failed start-up comes some 11k cycles later
    for (k = 0; k < 20 && val !== temp_poll_pkg::FAULT_READING; k++) begin
      repeat (1000) @(negedge core_clk);
      rd_temp(5'd17, val);
    end
    check("missing sensor", val, temp_poll_pkg::FAULT_READING);
    check("bus drive levels", {14'h0000, clk_out, data_out}, 16'h0000);
    check("status flag", {15'h0000, temp_status_flag}, 16'h0001);
    check("alert off", {15'h0000, temp_alert}, 16'h0000);
    mode_alert_enable = 1'b1;
    repeat (2) @(negedge core_clk);
    check("alert on", {15'h0000, temp_alert}, 16'h0001);
    $display("test round one done");
    status_clear = 1'b1;
    @(negedge core_clk);
    status_clear = 1'b0;
    repeat (2) @(negedge core_clk);
    check("flag cleared", {15'h0000, temp_status_flag}, 16'h0000);
    check("alert cleared", {15'h0000, temp_alert}, 16'h0000);
    cmd_wr(5'd14, 16'h0000);
    rd_temp(5'd14, val);
    check("disabled ext", val, temp_poll_pkg::DISABLED_READING);
    cmd_wr(5'd17, temp_poll_pkg::RETRY_WORD);
    cmd_rd(5'd17, temp_poll_pkg::CMD_CHANNEL_ENABLE, val);
    check("retry word", val, 16'h8000);
    // Second round: internal average four LSBs over the hot limit
    for (k = 0; k < 60000 && temp_status_flag !== 1'b1; k++) @(negedge core_clk);
    repeat (2) @(negedge core_clk);
    check("fault flag", {15'h0000, temp_status_flag}, 16'h0001);
    check("fault alert", {15'h0000, temp_alert}, 16'h0001);
    for (k = 0; k < 20 && val !== temp_poll_pkg::FAULT_READING; k++) rd_temp(5'd13, val);
    check("internal fault", val, temp_poll_pkg::FAULT_READING);
    rd_temp(5'd14, val);
    check("still disabled", val, temp_poll_pkg::DISABLED_READING);
    $display("test round two done");
    report_and_stop;
  end
endmodule

// [inc/temp_poll_pkg.sv]
// Constants shared by the temperature poller and its auxiliary bus master.
// Assumes a 100 MHz core clock and a separate link clock for the bus engine.
package temp_poll_pkg;
  // Host command codes and page numbers
  localparam logic [7:0] CMD_CHANNEL_ENABLE = 8'hF0;
  localparam logic [7:0] CMD_READ_TEMPERATURE = 8'h8D;
  localparam logic [4:0] PAGE_INTERNAL = 5'h0D;
  localparam logic [4:0] PAGE_LAST = 5'h11;
  localparam int NUM_CH = 5;
  // Enable word layout
  localparam int ENABLE_BIT = 15;
  localparam logic ENABLE_RESET = 1'b1;
  localparam logic [15:0] RETRY_WORD = 16'h8000;
  // Readings, LSB = 1/128 degree, two's complement
  localparam logic [15:0] FAULT_READING = 16'h7FFF;
  localparam logic [15:0] DISABLED_READING = 16'h0000;
  localparam logic [15:0] READING_RESET = 16'h0000;
  localparam logic [15:0] INT_HOT_LIMIT = 16'h4100;
  localparam logic [15:0] INT_COLD_LIMIT = 16'hE200;
  localparam int INT_AVG_COUNT = 4;
  // External sensor bus addresses (8-bit form) and sensor registers
  localparam logic [7:0] EXT_ADDR_BASE = 8'h90;
  localparam logic [7:0] SENSOR_PTR_TEMP = 8'h00;
  localparam logic [7:0] SENSOR_PTR_CONFIG = 8'h01;
  localparam logic [7:0] SENSOR_CONFIG_VALUE = 8'h60;
  // Timing
  localparam int CORE_CLK_HZ = 100_000_000;
  localparam int POLL_PERIOD_MS = 1000;
  localparam int POLL_CYCLES = CORE_CLK_HZ / 1000 * POLL_PERIOD_MS;
  localparam int AUX_BIT_RATE_HZ = 100_000;
  localparam int LINK_CLK_PERIOD_NS = 6;
  localparam int AUX_QUARTER_CYCLES = 1_000_000_000 / (4 * AUX_BIT_RATE_HZ) / LINK_CLK_PERIOD_NS;
  // Bus engine transaction steps
  typedef enum logic [6:0] {
    K_START = 7'h01, K_WR = 7'h02, K_RD_ACK = 7'h04, K_RD_NACK = 7'h08,
    K_RSTART = 7'h10, K_STOP = 7'h20, K_END = 7'h40
  } step_kind_t;
endpackage

// [rtl/aux_bus_master.sv]
// Two-wire master that initialises or reads one temperature sensor per request.
// Runs on link_clk; requests arrive as a toggle with quasi-static address/kind.
`timescale 1ns/1ps
module aux_bus_master (
  input wire logic link_clk,
  input wire logic rstn,
  input wire logic req_tgl,
  input wire logic [7:0] req_addr,
  input wire logic req_init,
  output logic ack_tgl,
  output logic [15:0] resp_data,
  output logic resp_ok,
  input wire logic aux_bus_clock_in,
  output logic aux_bus_clock_out,
  output logic aux_bus_clock_oe,
  input wire logic aux_bus_data_in,
  output logic aux_bus_data_out,
  output logic aux_bus_data_oe
);
  typedef enum logic [1:0] {L_IDLE = 2'b01, L_RUN = 2'b10} link_state_t;

  function automatic temp_poll_pkg::step_kind_t step_kind(input logic init, input logic [3:0] idx);
    if (init) begin
      case (idx)
        4'h0: step_kind = temp_poll_pkg::K_START;
        4'h1, 4'h2, 4'h3: step_kind = temp_poll_pkg::K_WR;
        4'h4: step_kind = temp_poll_pkg::K_STOP;
        default: step_kind = temp_poll_pkg::K_END;
      endcase
    end else begin
      case (idx)
        4'h0: step_kind = temp_poll_pkg::K_START;
        4'h1, 4'h2, 4'h4: step_kind = temp_poll_pkg::K_WR;
        4'h3: step_kind = temp_poll_pkg::K_RSTART;
        4'h5: step_kind = temp_poll_pkg::K_RD_ACK;
        4'h6: step_kind = temp_poll_pkg::K_RD_NACK;
        4'h7: step_kind = temp_poll_pkg::K_STOP;
        default: step_kind = temp_poll_pkg::K_END;
      endcase
    end
  endfunction

  function automatic logic [7:0] step_byte(input logic init, input logic [3:0] idx, input logic [7:0] addr);
    case (idx)
      4'h2: step_byte = init ? temp_poll_pkg::SENSOR_PTR_CONFIG : temp_poll_pkg::SENSOR_PTR_TEMP;
      4'h3: step_byte = temp_poll_pkg::SENSOR_CONFIG_VALUE;
      4'h4: step_byte = addr | 8'h01;
      default: step_byte = addr;
    endcase
  endfunction

  logic [1:0] rst_sync;
  logic req_s1, req_s2, req_seen, scl_s1, scl_s2, sda_s1, sda_s2;
  logic [15:0] div;
  logic tick, failed;
  link_state_t state;
  logic [3:0] idx, bitn;
  logic [1:0] q;
  logic [7:0] shreg;
  logic [15:0] rdata;
  temp_poll_pkg::step_kind_t kind;

  // Reset is released into this domain through two flops
  always_ff @(posedge link_clk) rst_sync <= {rst_sync[0], rstn};
  always_ff @(posedge link_clk) begin
    req_s1 <= req_tgl;
    req_s2 <= req_s1;
    scl_s1 <= aux_bus_clock_in;
    scl_s2 <= scl_s1;
    sda_s1 <= aux_bus_data_in;
    sda_s2 <= sda_s1;
  end

  always_ff @(posedge link_clk) begin
    if (!rst_sync[1] || div == 16'(temp_poll_pkg::AUX_QUARTER_CYCLES - 1)) begin
      div <= 16'h0000;
    end else begin
      div <= div + 16'h0001;
    end
  end
  assign tick = (div == 16'(temp_poll_pkg::AUX_QUARTER_CYCLES - 1));
  assign kind = step_kind(req_init, idx);
  assign aux_bus_clock_out = 1'b0;
  assign aux_bus_data_out = 1'b0;

  always_ff @(posedge link_clk) begin
    if (!rst_sync[1]) begin
      state <= L_IDLE;
      req_seen <= 1'b0;
      ack_tgl <= 1'b0;
      resp_data <= 16'h0000;
      resp_ok <= 1'b0;
      aux_bus_clock_oe <= 1'b0;
      aux_bus_data_oe <= 1'b0;
      idx <= 4'h0;
      bitn <= 4'h0;
      q <= 2'h0;
      shreg <= 8'h00;
      rdata <= 16'h0000;
      failed <= 1'b0;
    end else begin
      unique case (state)
        L_IDLE: begin
          if (req_s2 != req_seen) begin
            req_seen <= req_s2;
            state <= L_RUN;
            idx <= 4'h0;
            q <= 2'h0;
            bitn <= 4'h0;
            failed <= 1'b0;
          end
        end
        L_RUN: begin
          // Clock stretching: the high quarter waits for the wire to rise
          if (tick && !(q == 2'h2 && !scl_s2)) begin
            q <= q + 2'h1;
            unique case (kind)
              temp_poll_pkg::K_START: begin
                if (q == 2'h0) aux_bus_data_oe <= 1'b0;
                if (q == 2'h0) aux_bus_clock_oe <= 1'b0;
                if (q == 2'h1) aux_bus_data_oe <= 1'b1;
                if (q == 2'h2) aux_bus_clock_oe <= 1'b1;
              end
              temp_poll_pkg::K_RSTART: begin
                if (q == 2'h0) aux_bus_data_oe <= 1'b0;
                if (q == 2'h1) aux_bus_clock_oe <= 1'b0;
                if (q == 2'h2) aux_bus_data_oe <= 1'b1;
                if (q == 2'h3) aux_bus_clock_oe <= 1'b1;
              end
              temp_poll_pkg::K_STOP: begin
                if (q == 2'h0) aux_bus_data_oe <= 1'b1;
                if (q == 2'h1) aux_bus_clock_oe <= 1'b0;
                if (q == 2'h2) aux_bus_data_oe <= 1'b0;
              end
              temp_poll_pkg::K_END: begin
                resp_data <= rdata;
                resp_ok <= !failed;
                ack_tgl <= ~ack_tgl;
                state <= L_IDLE;
              end
              default: begin
                if (q == 2'h0) begin
                  if (kind == temp_poll_pkg::K_WR) begin
                    aux_bus_data_oe <= (bitn != 4'h8) && !shreg[7];
                  end else begin
                    aux_bus_data_oe <= (bitn == 4'h8) && (kind == temp_poll_pkg::K_RD_ACK);
                  end
                end
                if (q == 2'h1) aux_bus_clock_oe <= 1'b0;
                if (q == 2'h2 && kind != temp_poll_pkg::K_WR && bitn != 4'h8) rdata <= {rdata[14:0], sda_s2};
                if (q == 2'h2 && kind == temp_poll_pkg::K_WR && bitn == 4'h8 && sda_s2) failed <= 1'b1;
                if (q == 2'h3) begin
                  aux_bus_clock_oe <= 1'b1;
                  shreg <= {shreg[6:0], 1'b0};
                  bitn <= bitn + 4'h1;
                end
              end
            endcase
            if (q == 2'h3) begin
              if (kind == temp_poll_pkg::K_START || kind == temp_poll_pkg::K_RSTART ||
                  kind == temp_poll_pkg::K_STOP || bitn == 4'h8) begin
                bitn <= 4'h0;
                // A missing acknowledge skips straight to the stop condition
                if (failed && kind != temp_poll_pkg::K_STOP) begin
                  idx <= req_init ? 4'h4 : 4'h7;
                end else begin
                  idx <= idx + 4'h1;
                  shreg <= step_byte(req_init, idx + 4'h1, req_addr);
                end
              end
            end
          end
          if (idx == 4'h0 && q == 2'h0) shreg <= step_byte(req_init, 4'h0, req_addr);
        end
        default: state <= L_IDLE;
      endcase
    end
  end
endmodule

// [rtl/temp_sensor_poller.sv]
// Temperature poller: one internal and four external sensors, read once per second.
// Host command logic drives the command strobes on core_clk; sensors sit on the aux bus.
// Contract
// - Five channels: internal on page 13, external pages 14-17 at addresses 90h-96h.
// - Every enabled channel is measured once per second; disabled ones and sensors whose initialisation failed are skipped.
// - Internal reading is the average of four successive conversions.
// - Internal result above +130 or below -60 degrees is a fault.
// - Any failed bus access to an external sensor is a fault.
// - A faulted channel's reading becomes 7FFFh.
// - Fault sets the temperature status flag and alert if enabled.
// - Failed sensor initialisation flags a fault; retried only after 8000h is written.
// - Reading a disabled channel's temperature returns 0000h.
// - Enable word: bit 15 enables the channel, bits 14:0 read zero.
`timescale 1ns/1ps
module temp_sensor_poller #(
  parameter int POLL_CYCLES = temp_poll_pkg::POLL_CYCLES
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic link_clk,
  input wire logic [4:0] cmd_page,
  input wire logic [7:0] cmd_code,
  input wire logic cmd_write,
  input wire logic cmd_read,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] cmd_rdata,
  output logic cmd_rdata_valid,
  input wire logic status_clear,
  input wire logic mode_alert_enable,
  output logic int_start,
  input wire logic [15:0] int_sample,
  input wire logic int_sample_valid,
  output logic temp_status_flag,
  output logic temp_alert,
  input wire logic aux_bus_clock_in,
  output logic aux_bus_clock_out,
  output logic aux_bus_clock_oe,
  input wire logic aux_bus_data_in,
  output logic aux_bus_data_out,
  output logic aux_bus_data_oe
);
  typedef enum logic [4:0] {
    P_IDLE = 5'h01, P_PICK = 5'h02, P_INT = 5'h04, P_EXT_REQ = 5'h08, P_EXT_WAIT = 5'h10
  } poll_state_t;

  poll_state_t state;
  logic [31:0] sec_cnt;
  logic sec_tick;
  logic [2:0] ch;
  logic [1:0] ext_idx;
  logic [4:0] enable;
  logic [3:0] need_init, init_failed;
  logic [15:0] reading [temp_poll_pkg::NUM_CH];
  logic [1:0] avg_cnt;
  logic [17:0] avg_sum;
  logic [17:0] next_sum;
  logic [15:0] avg_val;
  logic req_tgl, req_init, ack_s1, ack_s2, ack_seen, ack_tgl, resp_ok;
  logic [7:0] req_addr;
  logic [15:0] resp_data;
  logic ack_evt, load_evt, fault_evt, retry_evt, cmd_valid_page;
  logic [15:0] load_val;
  logic [2:0] cmd_ch;

  assign cmd_ch = 3'(cmd_page - temp_poll_pkg::PAGE_INTERNAL);
  assign cmd_valid_page = (cmd_page >= temp_poll_pkg::PAGE_INTERNAL) && (cmd_page <= temp_poll_pkg::PAGE_LAST);
  assign ext_idx = 2'(ch - 3'h1);
  assign retry_evt = cmd_write && cmd_valid_page && cmd_code == temp_poll_pkg::CMD_CHANNEL_ENABLE &&
                     cmd_ch != 3'h0 && cmd_wdata == temp_poll_pkg::RETRY_WORD;

  // Once-per-second poll timer
  always_ff @(posedge core_clk) begin
    if (!rstn || sec_tick) begin
      sec_cnt <= 32'h0000_0000;
    end else begin
      sec_cnt <= sec_cnt + 32'h0000_0001;
    end
  end
  assign sec_tick = (sec_cnt == 32'(POLL_CYCLES - 1));

  // Response toggle from the link domain, two flops before use
  always_ff @(posedge core_clk) begin
    ack_s1 <= ack_tgl;
    ack_s2 <= ack_s1;
  end
  assign ack_evt = (ack_s2 != ack_seen);

  assign next_sum = avg_sum + {{2{int_sample[15]}}, int_sample};
  assign avg_val = next_sum[17:2];

  always_comb begin
    load_evt = 1'b0;
    fault_evt = 1'b0;
    load_val = temp_poll_pkg::FAULT_READING;
    if (state == P_INT && int_sample_valid && avg_cnt == 2'h3) begin
      load_evt = 1'b1;
      if ($signed(avg_val) > $signed(temp_poll_pkg::INT_HOT_LIMIT) ||
          $signed(avg_val) < $signed(temp_poll_pkg::INT_COLD_LIMIT)) begin
        fault_evt = 1'b1;
      end else begin
        load_val = avg_val;
      end
    end else if (state == P_EXT_WAIT && ack_evt) begin
      if (!resp_ok) begin
        load_evt = 1'b1;
        fault_evt = 1'b1;
      end else if (!req_init) begin
        load_evt = 1'b1;
        load_val = resp_data;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state <= P_IDLE;
      ch <= 3'h0;
      avg_cnt <= 2'h0;
      avg_sum <= 18'h0_0000;
      int_start <= 1'b0;
      req_tgl <= 1'b0;
      req_init <= 1'b0;
      req_addr <= temp_poll_pkg::EXT_ADDR_BASE;
      ack_seen <= 1'b0;
    end else begin
      int_start <= 1'b0;
      unique case (state)
        P_IDLE: begin
          if (sec_tick) begin
            ch <= 3'h0;
            state <= P_PICK;
          end
        end
        P_PICK: begin
          if (ch == 3'(temp_poll_pkg::NUM_CH)) begin
            state <= P_IDLE;
          end else if (!enable[ch] || (ch != 3'h0 && init_failed[ext_idx])) begin
            ch <= ch + 3'h1;
          end else if (ch == 3'h0) begin
            avg_cnt <= 2'h0;
            avg_sum <= 18'h0_0000;
            int_start <= 1'b1;
            state <= P_INT;
          end else begin
            state <= P_EXT_REQ;
          end
        end
        P_INT: begin
          if (int_sample_valid) begin
            avg_sum <= next_sum;
            avg_cnt <= avg_cnt + 2'h1;
            int_start <= (avg_cnt != 2'h3);
            if (avg_cnt == 2'h3) begin
              ch <= ch + 3'h1;
              state <= P_PICK;
            end
          end
        end
        P_EXT_REQ: begin
          req_init <= need_init[ext_idx];
          req_addr <= 8'(temp_poll_pkg::EXT_ADDR_BASE + {5'h00, ext_idx, 1'b0});
          req_tgl <= ~req_tgl;
          state <= P_EXT_WAIT;
        end
        P_EXT_WAIT: begin
          if (ack_evt) begin
            ack_seen <= ack_s2;
            // A good initialisation is followed at once by the first read
            if (req_init && resp_ok) begin
              state <= P_EXT_REQ;
            end else begin
              ch <= ch + 3'h1;
              state <= P_PICK;
            end
          end
        end
        default: state <= P_IDLE;
      endcase
    end
  end

  // Sensor initialisation bookkeeping; a new failure wins over a host retry
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      need_init <= 4'hF;
      init_failed <= 4'h0;
    end else begin
      if (retry_evt) begin
        need_init[2'(cmd_ch - 3'h1)] <= 1'b1;
        init_failed[2'(cmd_ch - 3'h1)] <= 1'b0;
      end
      if (state == P_EXT_WAIT && ack_evt && req_init) begin
        need_init[ext_idx] <= !resp_ok;
        if (!resp_ok) init_failed[ext_idx] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      for (int i = 0; i < temp_poll_pkg::NUM_CH; i++) reading[i] <= temp_poll_pkg::READING_RESET;
    end else if (load_evt) begin
      reading[ch] <= load_val;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      enable <= {temp_poll_pkg::NUM_CH{temp_poll_pkg::ENABLE_RESET}};
    end else if (cmd_write && cmd_valid_page && cmd_code == temp_poll_pkg::CMD_CHANNEL_ENABLE) begin
      enable[cmd_ch] <= cmd_wdata[temp_poll_pkg::ENABLE_BIT];
    end
  end

  // Status flag is sticky; a fault in the clearing cycle still sets it
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      temp_status_flag <= 1'b0;
      temp_alert <= 1'b0;
    end else begin
      temp_status_flag <= fault_evt || (temp_status_flag && !status_clear);
      temp_alert <= mode_alert_enable && (fault_evt || (temp_status_flag && !status_clear));
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cmd_rdata <= 16'h0000;
      cmd_rdata_valid <= 1'b0;
    end else begin
      cmd_rdata_valid <= cmd_read;
      cmd_rdata <= 16'h0000;
      if (cmd_read && cmd_valid_page) begin
        if (cmd_code == temp_poll_pkg::CMD_CHANNEL_ENABLE) begin
          cmd_rdata <= {enable[cmd_ch], 15'h0000};
        end else if (cmd_code == temp_poll_pkg::CMD_READ_TEMPERATURE) begin
          cmd_rdata <= enable[cmd_ch] ? reading[cmd_ch] : temp_poll_pkg::DISABLED_READING;
        end
      end
    end
  end

  aux_bus_master u_aux (
    .link_clk(link_clk),
    .rstn(rstn),
    .req_tgl(req_tgl),
    .req_addr(req_addr),
    .req_init(req_init),
    .ack_tgl(ack_tgl),
    .resp_data(resp_data),
    .resp_ok(resp_ok),
    .aux_bus_clock_in(aux_bus_clock_in),
    .aux_bus_clock_out(aux_bus_clock_out),
    .aux_bus_clock_oe(aux_bus_clock_oe),
    .aux_bus_data_in(aux_bus_data_in),
    .aux_bus_data_out(aux_bus_data_out),
    .aux_bus_data_oe(aux_bus_data_oe)
  );

  a_fault_sentinel: assert property (@(posedge core_clk) disable iff (!rstn)
    fault_evt |=> reading[$past(ch)] == temp_poll_pkg::FAULT_READING) else $error("fault reading not 7FFFh");
  a_flag_on_fault: assert property (@(posedge core_clk) disable iff (!rstn)
    fault_evt |=> temp_status_flag) else $error("status flag not set by fault");
  a_alert_gated: assert property (@(posedge core_clk) disable iff (!rstn)
    temp_alert |-> temp_status_flag && $past(mode_alert_enable)) else $error("alert without flag");
  a_hot_limit: assert property (@(posedge core_clk) disable iff (!rstn)
    load_evt && state == P_INT && $signed(avg_val) > $signed(16'h4100) |-> fault_evt) else $error("hot fault missed");
  a_disabled_zero: assert property (@(posedge core_clk) disable iff (!rstn)
    cmd_read && cmd_valid_page && cmd_code == 8'h8D && !enable[cmd_ch] |=> cmd_rdata == 16'h0000)
    else $error("disabled channel read not zero");
  a_cfg_low_zero: assert property (@(posedge core_clk) disable iff (!rstn)
    cmd_rdata_valid |-> cmd_rdata[14:0] == 15'h0000 || $past(cmd_code) != 8'hF0) else $error("enable low bits set");
  a_skip_disabled: assert property (@(posedge core_clk) disable iff (!rstn)
    state == P_EXT_REQ |-> enable[ch] && !init_failed[ext_idx]) else $error("disabled or failed sensor polled");
  a_avg_four: assert property (@(posedge core_clk) disable iff (!rstn)
    state == P_INT && int_sample_valid && avg_cnt == 2'h3 && !fault_evt |=> reading[0] == $past(avg_val))
    else $error("internal average not stored");
  a_reading_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    !load_evt |=> $stable(reading[4])) else $error("reading changed without update");
endmodule
